/* verilog/tpwp_top.sv */
// transmit partition write port: line assembly, fill, drain, apb
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none

module tpwp_top (
   input  wire logic                         core_clk,
   input  wire logic                         sys_rst,
   input  wire logic                         tx_write_clock,
   input  wire tpwp_pkg::tpwp_wr_s           tx_wr,
   input  wire logic                         buffer_service_disable,
   output logic                              partition_full_flag,
   input  wire logic                         arb_pop,
   input  wire logic [tpwp_pkg::PSEL_W-1:0]  arb_part,
   output logic [tpwp_pkg::LINE_W-1:0]       arb_line,
   output var tpwp_pkg::tpwp_meta_s          arb_meta,
   output logic                              arb_valid,
   output logic                              arb_idle,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [tpwp_pkg::APB_AW-1:0]  paddr,
   input  wire logic [31:0]                  pwdata,
   output logic [31:0]                       prdata,
   output logic                              pready,
   output logic                              pslverr
);
   import tpwp_pkg::*;

   // ------------------------------------------------------------
   // storage and state
   // ------------------------------------------------------------
   tpwp_core_s        st_reg;
   tpwp_core_s        st_next;
   logic [LINE_W-1:0] mem      [PARTS*PART_LINES];
   tpwp_meta_s        meta     [PARTS*PART_LINES];
   logic [LINE_W-1:0] line_reg;
   tpwp_meta_s        line_meta_reg;

   // crossed write port
   logic              wr_take;
   tpwp_wr_s          wr_held;
   logic [PSEL_W-1:0] sel_sync;
   logic              dis_sync;

   // decode
   logic [PSEL_W-1:0] wp;
   logic [1:0]        widx;
   logic [CNT_W-1:0]  fill_wp;
   logic [PTR_W-1:0]  wptr_wp;
   logic [CNT_W-1:0]  fill_rp;
   logic              room;
   logic              wr_go;
   logic              term_go;
   logic              commit;
   logic              sop_acc;
   logic              be_ok;
   logic              rd_go;
   logic [ROW_W-1:0]  wrow;
   logic [ROW_W-1:0]  rrow;
   logic [WORD_W-1:0] bmask;
   tpwp_meta_s        meta_val;
   logic [PARTS-1:0]  inc;
   logic [PARTS-1:0]  dec;
   logic [PARTS-1:0]  full_vec;
   logic [31:0]       occ_vec;
   logic              apb_acc;
   logic              apb_wr;
   logic              unmapped;
   logic [31:0]       rdata;

   // ------------------------------------------------------------
   // clock crossing of the write port
   // ------------------------------------------------------------
   tpwp_sync u_sync (
      .core_clk            (core_clk),
      .sys_rst             (sys_rst),
      .tx_write_clock      (tx_write_clock),
      .tx_wr               (tx_wr),
      .service_disable_pin (buffer_service_disable),
      .wr_take             (wr_take),
      .wr_held             (wr_held),
      .sel_sync            (sel_sync),
      .disable_sync        (dis_sync)
   );

   // ------------------------------------------------------------
   // write decode
   // ------------------------------------------------------------
   // a full partition refuses words and terminates alike: the write row
   // would then alias the oldest unread line
   assign wp      = wr_held.partition_write_select;
   assign widx    = st_reg.word_idx[wp];
   assign fill_wp = st_reg.fill[wp];
   assign wptr_wp = st_reg.wr_ptr[wp];
   assign room    = fill_wp != CNT_W'(PART_LINES);
   assign wr_go   = wr_take && wr_held.tx_write_strobe && room
                    && (wr_held.tx_byte_valid != BE_NONE);
   assign term_go = wr_take && wr_held.line_write_terminate && room;
   assign commit  = term_go || (wr_go && ((widx == LAST_WORD)
                    || wr_held.packet_end_flag));
   assign wrow    = {wp, wptr_wp};
   assign sop_acc = (widx == 2'h0) ? wr_held.packet_start_flag
                                   : st_reg.sop_hold[wp];
   assign be_ok   = (wr_held.tx_byte_valid == BE_FOUR)
                    || (wr_held.tx_byte_valid == BE_THREE)
                    || (wr_held.tx_byte_valid == BE_ONE);

   // line descriptor, rewritten with every word of the line
   assign meta_val.port    = wr_held.logical_port_number;
   assign meta_val.sop     = sop_acc;
   assign meta_val.eop     = wr_go && wr_held.packet_end_flag;
   assign meta_val.err     = wr_go && wr_held.packet_end_flag
                             && wr_held.packet_abort_flag;
   assign meta_val.last_be = wr_go ? wr_held.tx_byte_valid : BE_NONE;
   assign meta_val.words   = wr_go ? ({1'b0, widx} + 3'h1)
                                   : {1'b0, widx};

   // arbiter side: disabled buffer is never read
   assign fill_rp = st_reg.fill[arb_part];
   assign rd_go   = arb_pop && !dis_sync && (fill_rp != '0);
   assign rrow    = {arb_part, st_reg.rd_ptr[arb_part]};

   // ------------------------------------------------------------
   // per-byte lane masks and per-partition bookkeeping
   // ------------------------------------------------------------
   for (genvar b = 0; b < BE_W; b++) begin : g_lane
      assign bmask[8*b +: 8] = {8{wr_held.tx_byte_valid[b]}};
   end

   for (genvar i = 0; i < PARTS; i++) begin : g_part
      assign inc[i] = commit && (wp == PSEL_W'(i));
      assign dec[i] = rd_go && (arb_part == PSEL_W'(i));
      assign full_vec[i] = st_reg.fill[i] >= st_reg.thresh;
      assign occ_vec[OCC_NIB*i +: OCC_NIB] = OCC_NIB'(st_reg.fill[i]);
   end

   // ------------------------------------------------------------
   // apb slave, one wait state on every access
   // ------------------------------------------------------------
   assign apb_acc  = psel && penable;
   assign apb_wr   = apb_acc && st_reg.pready && pwrite;
   assign unmapped = (paddr != ADDR_CTRL) && (paddr != ADDR_OCC)
                     && (paddr != ADDR_FLAGS);

   // read mux; unmapped offsets read zero with an error
   always_comb begin
      rdata = '0;
      case (paddr)
         ADDR_CTRL: begin
            rdata[CNT_W-1:0] = st_reg.thresh;
         end
         ADDR_OCC: begin
            rdata = occ_vec;
         end
         ADDR_FLAGS: begin
            rdata[FLG_FAULT_BIT] = st_reg.pat_fault;
            rdata[FLG_DIS_BIT]   = dis_sync;
            rdata[FLG_FULL_LSB +: PARTS] = full_vec;
         end
         default: begin
            rdata = '0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      st_next           = st_reg;
      st_next.arb_valid = rd_go;
      st_next.arb_idle  = arb_pop && !rd_go;
      // line assembly; terminate closes even a short or empty line
      if (commit) begin
         st_next.wr_ptr[wp]   = PTR_W'(wptr_wp + 1'b1);
         st_next.word_idx[wp] = 2'h0;
         st_next.sop_hold[wp] = 1'b0;
      end else if (wr_go) begin
         st_next.word_idx[wp] = widx + 2'h1;
         st_next.sop_hold[wp] = sop_acc;
      end
      if (rd_go) begin
         st_next.rd_ptr[arb_part] = PTR_W'(st_reg.rd_ptr[arb_part] + 1'b1);
      end
      // occupancy counts whole lines, independent of the disable
      for (int i = 0; i < PARTS; i++) begin
         st_next.fill[i] = st_reg.fill[i] + CNT_W'(inc[i])
                           - CNT_W'(dec[i]);
      end
      // status for the partition the user is presenting now
      st_next.full = st_next.fill[sel_sync] >= st_reg.thresh;
      // pattern fault is sticky; a new fault beats a clear
      if (apb_wr && (paddr == ADDR_FLAGS) && pwdata[FLG_FAULT_BIT]) begin
         st_next.pat_fault = 1'b0;
      end
      if (wr_go && !be_ok) begin
         st_next.pat_fault = 1'b1;
      end
      if (apb_wr && (paddr == ADDR_CTRL)) begin
         st_next.thresh = pwdata[CNT_W-1:0];
      end
      st_next.pready  = apb_acc && !st_reg.pready;
      st_next.pslverr = st_next.pready && unmapped;
      st_next.prdata  = st_next.pready ? rdata : '0;
   end

   // ------------------------------------------------------------
   // registers and buffer ram
   // ------------------------------------------------------------
   // the ram has no reset: only committed lines are ever read
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_reg        <= '0;
         st_reg.thresh <= THRESH_RST;
         line_reg      <= '0;
         line_meta_reg <= '0;
      end else begin
         st_reg <= st_next;
         if (rd_go) begin
            line_reg      <= mem[rrow];
            line_meta_reg <= meta[rrow];
         end
      end
      if (wr_go) begin
         mem[wrow][{widx, 5'h00} +: WORD_W] <=
            wr_held.tx_write_word & bmask;
      end
      if (wr_go || term_go) begin
         meta[wrow] <= meta_val;
      end
   end

   // outputs straight from flip-flops
   assign partition_full_flag = st_reg.full;
   assign arb_line            = line_reg;
   assign arb_meta            = line_meta_reg;
   assign arb_valid           = st_reg.arb_valid;
   assign arb_idle            = st_reg.arb_idle;
   assign prdata              = st_reg.prdata;
   assign pready              = st_reg.pready;
   assign pslverr             = st_reg.pslverr;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   chk_term_advance: assert property (
      term_go |=> st_reg.wr_ptr[$past(wp)] == PTR_W'($past(wptr_wp) + 1'b1))
      else $error("terminate did not move to the next line");

   chk_off_no_read: assert property (
      dis_sync |=> !arb_valid)
      else $error("line read while service disabled");

   chk_resume_serve: assert property (
      !dis_sync && arb_pop && (fill_rp != '0) |=> arb_valid && !arb_idle)
      else $error("enabled poll with data was not served");

   chk_idle_insert: assert property (
      dis_sync && arb_pop |=> arb_idle && !arb_valid)
      else $error("disabled poll did not report idle");

   chk_fill_when_off: assert property (
      dis_sync && commit
      |=> st_reg.fill[$past(wp)] == CNT_W'($past(fill_wp) + 1'b1))
      else $error("disabled buffer did not fill");

   chk_full_status: assert property (
      !$past(sys_rst) |-> partition_full_flag
         == (st_reg.fill[$past(sel_sync)] >= $past(st_reg.thresh)))
      else $error("full flag does not match selected occupancy");

   chk_full_release: assert property (
      $fell(partition_full_flag) && $stable(st_reg.thresh)
      |-> st_reg.fill[$past(sel_sync)] < st_reg.thresh)
      else $error("full flag dropped above threshold");

   chk_empty_drop: assert property (
      wr_take && wr_held.tx_write_strobe && !wr_held.line_write_terminate
      && (wr_held.tx_byte_valid == BE_NONE)
      |=> $stable(st_reg.word_idx) && $stable(st_reg.wr_ptr))
      else $error("word without byte valids was stored");

   chk_strobe_gate: assert property (
      wr_take && !wr_held.tx_write_strobe && !wr_held.line_write_terminate
      |=> $stable(st_reg.word_idx) && $stable(st_reg.wr_ptr))
      else $error("word stored without write strobe");

   chk_end_advance: assert property (
      wr_go && wr_held.packet_end_flag
      |=> (st_reg.word_idx[$past(wp)] == 2'h0)
          && (st_reg.wr_ptr[$past(wp)] == PTR_W'($past(wptr_wp) + 1'b1)))
      else $error("packet end did not close the line");

   chk_pattern_fault: assert property (
      wr_go && !be_ok |=> st_reg.pat_fault)
      else $error("bad byte valid pattern not flagged");
endmodule : tpwp_top

`default_nettype wire

/* verilog/tpwp_pkg.sv */
// shared constants and carriers of the transmit partition write port
package tpwp_pkg;
   // ------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------
   localparam int PARTS          = 8;
   localparam int PSEL_W         = 3;
   localparam int PART_LINES     = 4;
   localparam int PTR_W          = 2;
   localparam int CNT_W          = 3;
   localparam int ROW_W          = PSEL_W + PTR_W;
   localparam int WORD_W         = 32;
   localparam int WORDS_PER_LINE = 4;
   localparam int LINE_W         = WORD_W * WORDS_PER_LINE;
   localparam int BE_W           = 4;
   localparam int PORT_W         = 8;
   localparam int WCNT_W         = 3;
   localparam int OCC_NIB        = 4;
   localparam logic [1:0]      LAST_WORD  = 2'h3;
   localparam logic [BE_W-1:0] BE_NONE    = 4'h0;
   localparam logic [BE_W-1:0] BE_FOUR    = 4'hf;
   localparam logic [BE_W-1:0] BE_THREE   = 4'he;
   localparam logic [BE_W-1:0] BE_ONE     = 4'h8;
   localparam logic [CNT_W-1:0] THRESH_RST = 3'h4;

   // ------------------------------------------------------------
   // apb map
   // ------------------------------------------------------------
   localparam int APB_AW = 8;
   localparam logic [APB_AW-1:0] ADDR_CTRL  = 8'h00;
   localparam logic [APB_AW-1:0] ADDR_OCC   = 8'h04;
   localparam logic [APB_AW-1:0] ADDR_FLAGS = 8'h08;
   localparam int FLG_FAULT_BIT = 0;
   localparam int FLG_DIS_BIT   = 1;
   localparam int FLG_FULL_LSB  = 8;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [PSEL_W-1:0] partition_write_select;
      logic [WORD_W-1:0] tx_write_word;
      logic [BE_W-1:0]   tx_byte_valid;
      logic              packet_start_flag;
      logic              packet_end_flag;
      logic              packet_abort_flag;
      logic              tx_write_strobe;
      logic              line_write_terminate;
      logic [PORT_W-1:0] logical_port_number;
   } tpwp_wr_s;

   typedef struct packed {
      logic [PORT_W-1:0] port;
      logic              sop;
      logic              eop;
      logic              err;
      logic [BE_W-1:0]   last_be;
      logic [WCNT_W-1:0] words;
   } tpwp_meta_s;

   typedef struct packed {
      tpwp_wr_s b1;
      tpwp_wr_s b2;
      tpwp_wr_s held;
      logic     c1;
      logic     c2;
      logic     c3;
      logic     d1;
      logic     d2;
      logic     take;
   } tpwp_sync_s;

   typedef struct packed {
      logic [PARTS-1:0][PTR_W-1:0] wr_ptr;
      logic [PARTS-1:0][PTR_W-1:0] rd_ptr;
      logic [PARTS-1:0][1:0]       word_idx;
      logic [PARTS-1:0][CNT_W-1:0] fill;
      logic [PARTS-1:0]            sop_hold;
      logic [CNT_W-1:0]            thresh;
      logic                        pat_fault;
      logic                        full;
      logic                        arb_valid;
      logic                        arb_idle;
      logic                        pready;
      logic                        pslverr;
      logic [31:0]                 prdata;
   } tpwp_core_s;
endpackage : tpwp_pkg

/* verilog/tpwp_sync.sv */
// write-clock synchroniser and beat capture for one transmit write port
`timescale 1ns/1ns
`default_nettype none

module tpwp_sync (
   input  wire logic                         core_clk,
   input  wire logic                         sys_rst,
   input  wire logic                         tx_write_clock,
   input  wire tpwp_pkg::tpwp_wr_s           tx_wr,
   input  wire logic                         service_disable_pin,
   output logic                              wr_take,
   output var tpwp_pkg::tpwp_wr_s            wr_held,
   output logic [tpwp_pkg::PSEL_W-1:0]       sel_sync,
   output logic                              disable_sync
);
   import tpwp_pkg::*;

   tpwp_sync_s st_reg;
   tpwp_sync_s st_next;

   // ------------------------------------------------------------
   // two-stage capture of pins, beat taken on the falling edge
   // ------------------------------------------------------------
   // the user changes the bundle just after its rising edge, so the
   // mid-period falling edge is where the bundle is surely settled
   always_comb begin
      st_next      = st_reg;
      st_next.b1   = tx_wr;
      st_next.b2   = st_reg.b1;
      st_next.c1   = tx_write_clock;
      st_next.c2   = st_reg.c1;
      st_next.c3   = st_reg.c2;
      st_next.d1   = service_disable_pin;
      st_next.d2   = st_reg.d1;
      st_next.take = st_reg.c3 && !st_reg.c2;
      if (st_next.take) begin
         st_next.held = st_reg.b2;
      end
   end

   // state register
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state register
   assign wr_take      = st_reg.take;
   assign wr_held      = st_reg.held;
   assign sel_sync     = st_reg.b2.partition_write_select;
   assign disable_sync = st_reg.d2;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence s_clk_fall;
      st_reg.c2 ##1 !st_reg.c2;
   endsequence

   chk_take_on_fall: assert property (
      s_clk_fall |=> st_reg.take && (st_reg.held == $past(st_reg.b2)))
      else $error("write beat not taken on write clock fall");

   chk_take_single: assert property (
      st_reg.take |=> !st_reg.take)
      else $error("one write clock fall gave two beats");
endmodule : tpwp_sync

`default_nettype wire

/* verification/tpwp_user_model.sv */
// user-side write model: one beat per write-clock period
`timescale 1ns/1ns
`default_nettype none

module tpwp_user_model (
   input  wire logic         tx_write_clock,
   output var tpwp_pkg::tpwp_wr_s tx_wr
);
   import tpwp_pkg::*;
   // ------------------------------------------------------------
   // beat driver
   // ------------------------------------------------------------
   initial tx_wr = '0;

   // beat changes just after the user clock rises
   task automatic put_beat(input tpwp_wr_s w);
      @(posedge tx_write_clock);
      tx_wr <= w;
   endtask : put_beat

   // released bus shows inverted data, so a stale word cannot match
   task automatic release_bus(input logic [2:0] sel);
      @(posedge tx_write_clock);
      tx_wr <= '{sel, ~tx_wr.tx_write_word, 4'h0, 1'b0, 1'b0, 1'b0,
                 1'b0, 1'b0, ~tx_wr.logical_port_number};
   endtask : release_bus
endmodule : tpwp_user_model

`default_nettype wire

/* verification/tb.sv */
// testbench of the transmit partition write port
`timescale 1ns/1ns
`default_nettype none

module tb;
   import tpwp_pkg::*;
   // ------------------------------------------------------------
   // stimulus and observed signals
   // ------------------------------------------------------------
   logic             core_clk = 1'b0;
   logic             sys_rst = 1'b1;
   logic             tx_write_clock = 1'b0;
   logic             buffer_service_disable = 1'b0;
   logic             arb_pop = 1'b0;
   logic [2:0]       arb_part = 3'h0;
   logic             psel = 1'b0;
   logic             penable = 1'b0;
   logic             pwrite = 1'b0;
   logic [7:0]       paddr = 8'h00;
   logic [31:0]      pwdata = 32'h0000_0000;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   logic             partition_full_flag;
   logic             arb_valid;
   logic             arb_idle;
   logic [127:0]     arb_line;
   tpwp_meta_s       arb_meta;
   tpwp_wr_s         tx_wr;
   logic [31:0]      rd;
   logic             er;
   int               errors = 0;
   int               samples_checked = 0;

   always #50 core_clk = ~core_clk;
   // user clock unrelated in phase to the core clock
   initial begin
      #137;
      forever #400 tx_write_clock = ~tx_write_clock;
   end

   tpwp_top uut (.core_clk(core_clk), .sys_rst(sys_rst),
      .tx_write_clock(tx_write_clock), .tx_wr(tx_wr),
      .buffer_service_disable(buffer_service_disable),
      .partition_full_flag(partition_full_flag), .arb_pop(arb_pop),
      .arb_part(arb_part), .arb_line(arb_line), .arb_meta(arb_meta),
      .arb_valid(arb_valid), .arb_idle(arb_idle), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   tpwp_user_model user (.tx_write_clock(tx_write_clock), .tx_wr(tx_wr));

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run

   task automatic chk(input string nm, input logic [127:0] e, g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // apb transfer; the wait for pready is bounded
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         errors++;
         complete_run();
      end
   endtask : apb

   // user beat; logical port number derived from the partition
   task automatic wb(input logic [2:0] s, input logic [31:0] d,
      input logic [3:0] be, input logic sop, eop, err, we, tm);
      user.put_beat('{s, d, be, sop, eop, err, we, tm, 8'h10 | {5'h0, s}});
   endtask : wb

   // release the bus and let the last beat cross into the core clock
   task automatic fin(input logic [2:0] s);
      user.release_bus(s);
      repeat (8) @(posedge core_clk);
   endtask : fin

   task automatic pop(input logic [2:0] p);
      @(posedge core_clk);
      arb_pop <= 1'b1;
      arb_part <= p;
      @(posedge core_clk);
      arb_pop <= 1'b0;
      // valid or idle stands in the cycle after the pop edge; sample at its end
      @(posedge core_clk);
   endtask : pop

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk("full_at_reset", 1'b0, partition_full_flag);
      apb(1'b0, ADDR_CTRL, 32'h0000_0000);
      chk("ctrl_reset", 32'h0000_0004, rd);
      chk("ctrl_no_err", 1'b0, er);
      apb(1'b1, ADDR_CTRL, 32'h0000_0005);
      apb(1'b0, ADDR_CTRL, 32'h0000_0000);
      chk("ctrl_rw", 32'h0000_0005, rd);
      apb(1'b1, ADDR_CTRL, 32'h0000_0004);
      apb(1'b0, 8'h0c, 32'h0000_0000);
      chk("unmapped_err", 1'b1, er);
      $display("test registers done");
      // full line with dropped beats and a three-byte end
      wb(3'h2, 32'h1234_5670, 4'hf, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
      wb(3'h2, 32'hdead_0001, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      wb(3'h2, 32'hdead_0002, 4'hf, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      wb(3'h2, 32'h1234_5671, 4'hf, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      wb(3'h2, 32'h1234_5672, 4'hf, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      wb(3'h2, 32'h1234_5673, 4'he, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
      fin(3'h2);
      pop(3'h2);
      chk("line_valid", 1'b1, arb_valid);
      chk("line_data", {32'h1234_5600, 96'h1234_5672_1234_5671_1234_5670},
          arb_line);
      chk("line_meta", {8'h12, 3'b110, 4'he, 3'h4}, arb_meta);
      // single-byte end and an abort with a four-byte end
      wb(3'h3, 32'hab12_3456, 4'h8, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
      wb(3'h5, 32'h5566_7788, 4'hf, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
      // one word then a terminate pulse closes the line early
      wb(3'h4, 32'h0bad_cafe, 4'hf, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
      wb(3'h4, 32'h0000_0000, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      fin(3'h4);
      pop(3'h3);
      chk("one_byte", 32'hab00_0000, arb_line[31:0]);
      chk("one_byte_meta", {8'h13, 3'b110, 4'h8, 3'h1}, arb_meta);
      pop(3'h5);
      chk("abort_meta", {8'h15, 3'b111, 4'hf, 3'h1}, arb_meta);
      pop(3'h4);
      chk("term_words", 3'h1, arb_meta.words);
      chk("term_eop", 1'b0, arb_meta.eop);
      // an unlisted byte valid pattern is stored but raises the sticky fault
      wb(3'h6, 32'h0102_0304, 4'h3, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
      fin(3'h6);
      apb(1'b0, ADDR_FLAGS, 32'h0000_0000);
      chk("fault_set", 1'b1, rd[FLG_FAULT_BIT]);
      apb(1'b1, ADDR_FLAGS, 32'h0000_0001);
      apb(1'b0, ADDR_FLAGS, 32'h0000_0000);
      chk("fault_clear", 1'b0, rd[FLG_FAULT_BIT]);
      pop(3'h6);
      chk("odd_be_lanes", 32'h0000_0304, arb_line[31:0]);
      $display("test line assembly done");
      // fill a disabled partition, check full, idle and resume
      buffer_service_disable <= 1'b1;
      repeat (4)
         wb(3'h1, 32'h0000_0000, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      fin(3'h1);
      chk("full_set", 1'b1, partition_full_flag);
      pop(3'h1);
      chk("dis_idle", 2'b01, {arb_valid, arb_idle});
      apb(1'b0, ADDR_OCC, 32'h0000_0000);
      chk("occupancy", 32'h0000_0040, rd);
      apb(1'b0, ADDR_FLAGS, 32'h0000_0000);
      chk("flags", 32'h0000_0202, rd & 32'h0000_ff03);
      fin(3'h0);
      chk("full_follows_sel", 1'b0, partition_full_flag);
      buffer_service_disable <= 1'b0;
      repeat (4) @(posedge core_clk);
      pop(3'h1);
      chk("resume", 2'b10, {arb_valid, arb_idle});
      fin(3'h1);
      chk("full_clear", 1'b0, partition_full_flag);
      pop(3'h7);
      chk("empty_idle", 2'b01, {arb_valid, arb_idle});
      $display("test disable and full done");
      complete_run();
   end
endmodule : tb

`default_nettype wire
